// file: core/ir_pulse_encode_decode.sv
// Infrared pulse encoder and decoder between a UART and an infrared transceiver.
`timescale 1ns/1ps
module ir_pulse_encode_decode
    import ir_codec_pkg::*;
#(
    parameter int FIFO_WIDTH = FIFO_WIDTH_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // System clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // UART side
    input  wire logic x16_bit_clock_in,
    input  wire logic uart_tx_line_in,
    output logic      uart_rx_line_out,
    // Transceiver side
    input  wire logic ir_pulse_in,
    output logic      ir_pulse_out,
    // Control and status
    input  wire logic decoder_reset_n_in,
    output logic      tx_overrun_out
);

    generate
        if (FIFO_WIDTH < 1) begin : g_bad_width
            $error("ir_pulse_encode_decode: FIFO_WIDTH must be at least 1");
        end
    endgenerate

    // Input synchronisers.
    logic [SYNC_LANES-1:0] meta_reg;
    logic [SYNC_LANES-1:0] meta_next;
    logic [SYNC_LANES-1:0] sync_reg;
    logic [SYNC_LANES-1:0] sync_next;
    logic [SYNC_LANES-1:0] last_reg;
    logic [SYNC_LANES-1:0] last_next;
    logic                  tick;
    logic                  tx_fall;
    logic                  ir_fall;
    logic                  tx_level;

    always_comb begin
        meta_next = {ir_pulse_in, uart_tx_line_in, x16_bit_clock_in};
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= SYNC_RESET;
            sync_reg <= SYNC_RESET;
            last_reg <= SYNC_RESET;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign tick     = sync_reg[SYNC_CLK] & ~last_reg[SYNC_CLK];
    assign tx_fall  = ~sync_reg[SYNC_TX] & last_reg[SYNC_TX];
    assign ir_fall  = ~sync_reg[SYNC_IR] & last_reg[SYNC_IR];
    assign tx_level = sync_reg[SYNC_TX];

    // Space-bit framer: one event per low bit time on the transmit line.
    logic                  bit_active_reg;
    logic                  bit_active_next;
    logic [TICK_CNT_W-1:0] bit_cnt_reg;
    logic [TICK_CNT_W-1:0] bit_cnt_next;
    logic                  overrun_reg;
    logic                  overrun_next;
    logic                  push;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;
    logic                  fifo_out_ready;

    always_comb begin
        bit_active_next = bit_active_reg;
        bit_cnt_next    = bit_cnt_reg;
        push            = 1'b0;
        if (tx_fall) begin
            push            = 1'b1;
            bit_active_next = 1'b1;
            bit_cnt_next    = TICK_ZERO;
        end else if (bit_active_reg && tick) begin
            if (bit_cnt_reg == BIT_TICKS - 1'b1) begin
                bit_cnt_next = TICK_ZERO;
                if (tx_level == SPACE_LEVEL) begin
                    push = 1'b1;
                end else begin
                    bit_active_next = 1'b0;
                end
            end else begin
                bit_cnt_next = bit_cnt_reg + 1'b1;
            end
        end
        // A lost event can only be reported; the UART line has no way to wait.
        overrun_next = overrun_reg | (push & ~fifo_in_ready);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bit_active_reg <= 1'b0;
            bit_cnt_reg    <= TICK_ZERO;
            overrun_reg    <= 1'b0;
        end else begin
            bit_active_reg <= bit_active_next;
            bit_cnt_reg    <= bit_cnt_next;
            overrun_reg    <= overrun_next;
        end
    end

    ir_event_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_event_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push),
        .in_data_in    ({FIFO_WIDTH{tx_level}}),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_out_ready)
    );

    // Encoder. Only the system reset touches it.
    enc_state_type         enc_state_reg;
    enc_state_type         enc_state_next;
    logic [TICK_CNT_W-1:0] enc_cnt_reg;
    logic [TICK_CNT_W-1:0] enc_cnt_next;
    logic                  enc_pulse_reg;
    logic                  enc_pulse_next;

    assign fifo_out_ready = (enc_state_reg == ENC_IDLE);

    always_comb begin
        enc_state_next = enc_state_reg;
        enc_cnt_next   = enc_cnt_reg;
        enc_pulse_next = enc_pulse_reg;
        case (enc_state_reg)
            ENC_IDLE: begin
                enc_pulse_next = 1'b0;
                if (fifo_out_valid && fifo_out_data[0] == SPACE_LEVEL) begin
                    enc_state_next = ENC_WAIT;
                    enc_cnt_next   = TICK_ZERO;
                end
            end
            ENC_WAIT: begin
                if (tick) begin
                    if (enc_cnt_reg == ENC_DELAY_TICKS - 1'b1) begin
                        enc_state_next = ENC_PULSE;
                        enc_cnt_next   = TICK_ZERO;
                        enc_pulse_next = 1'b1;
                    end else begin
                        enc_cnt_next = enc_cnt_reg + 1'b1;
                    end
                end
            end
            ENC_PULSE: begin
                if (tick) begin
                    if (enc_cnt_reg == ENC_PULSE_TICKS - 1'b1) begin
                        enc_state_next = ENC_IDLE;
                        enc_cnt_next   = TICK_ZERO;
                        enc_pulse_next = 1'b0;
                    end else begin
                        enc_cnt_next = enc_cnt_reg + 1'b1;
                    end
                end
            end
            default: begin
                enc_state_next = ENC_IDLE;
                enc_cnt_next   = TICK_ZERO;
                enc_pulse_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enc_state_reg <= ENC_IDLE;
            enc_cnt_reg   <= TICK_ZERO;
            enc_pulse_reg <= 1'b0;
        end else begin
            enc_state_reg <= enc_state_next;
            enc_cnt_reg   <= enc_cnt_next;
            enc_pulse_reg <= enc_pulse_next;
        end
    end

    // Decoder.
    dec_state_type         dec_state_reg;
    dec_state_type         dec_state_next;
    logic [TICK_CNT_W-1:0] dec_cnt_reg;
    logic [TICK_CNT_W-1:0] dec_cnt_next;
    logic                  dec_rx_reg;
    logic                  dec_rx_next;
    logic                  dec_hold;

    assign dec_hold = rst_in | ~decoder_reset_n_in;

    always_comb begin
        dec_state_next = dec_state_reg;
        dec_cnt_next   = dec_cnt_reg;
        dec_rx_next    = dec_rx_reg;
        if (ir_fall) begin
            dec_state_next = DEC_STRETCH;
            dec_cnt_next   = TICK_ZERO;
            dec_rx_next    = 1'b0;
        end else begin
            case (dec_state_reg)
                DEC_IDLE: begin
                    dec_rx_next = 1'b1;
                end
                DEC_STRETCH: begin
                    if (tick) begin
                        if (dec_cnt_reg == BIT_TICKS - 1'b1) begin
                            dec_state_next = DEC_IDLE;
                            dec_cnt_next   = TICK_ZERO;
                            dec_rx_next    = 1'b1;
                        end else begin
                            dec_cnt_next = dec_cnt_reg + 1'b1;
                        end
                    end
                end
                default: begin
                    dec_state_next = DEC_IDLE;
                    dec_rx_next    = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (dec_hold) begin
            dec_state_reg <= DEC_IDLE;
            dec_cnt_reg   <= TICK_ZERO;
            dec_rx_reg    <= 1'b1;
        end else begin
            dec_state_reg <= dec_state_next;
            dec_cnt_reg   <= dec_cnt_next;
            dec_rx_reg    <= dec_rx_next;
        end
    end

    assign uart_rx_line_out = dec_rx_reg;
    assign ir_pulse_out     = enc_pulse_reg;
    assign tx_overrun_out   = overrun_reg;

    // Helper counters read only by the assertions below.
    logic [TICK_CNT_W-1:0] chk_wait_reg;
    logic [TICK_CNT_W-1:0] chk_high_reg;
    logic [TICK_CNT_W-1:0] chk_low_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chk_wait_reg <= TICK_ZERO;
            chk_high_reg <= TICK_ZERO;
        end else begin
            chk_wait_reg <= (enc_state_reg != ENC_WAIT) ? TICK_ZERO :
                            (tick ? chk_wait_reg + 1'b1 : chk_wait_reg);
            chk_high_reg <= (enc_state_reg != ENC_PULSE) ? TICK_ZERO :
                            (tick ? chk_high_reg + 1'b1 : chk_high_reg);
        end
    end

    always_ff @(posedge clk_in) begin
        if (dec_hold || ir_fall) begin
            chk_low_reg <= TICK_ZERO;
        end else if (dec_state_reg == DEC_STRETCH && tick) begin
            chk_low_reg <= chk_low_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_enc_delay_ticks: assert property (
        $rose(ir_pulse_out) |-> chk_wait_reg == 5'h07)
        else $error("Encoder pulse did not start seven ticks after the edge.");

    a_enc_pulse_width: assert property (
        $fell(ir_pulse_out) |-> chk_high_reg == 5'h03)
        else $error("Encoder pulse was not three ticks wide.");

    a_enc_idle_low: assert property (
        enc_state_reg == ENC_IDLE |-> !ir_pulse_out)
        else $error("Encoder output high while idle.");

    a_space_event_queued: assert property (
        tx_fall && fifo_in_ready |=> fifo_out_valid)
        else $error("Transmit falling edge was not queued.");

    a_enc_runs_on: assert property (
        $past(enc_state_reg) == ENC_WAIT && !$past(tick) |-> enc_state_reg == ENC_WAIT)
        else $error("Encoder left its wait without a tick.");

    a_dec_stretch_len: assert property (
        $rose(uart_rx_line_out) && !$past(dec_hold) |-> chk_low_reg == 5'h10)
        else $error("Stretched low level did not last sixteen ticks.");

    a_dec_edge_low: assert property (
        ir_fall && decoder_reset_n_in ##1 decoder_reset_n_in |-> !uart_rx_line_out)
        else $error("Receive edge did not drive the UART line low.");

    a_dec_idle_high: assert property (
        dec_state_reg == DEC_IDLE |-> uart_rx_line_out)
        else $error("UART receive line low while decoder idle.");

    a_dec_hold_blocks: assert property (
        !decoder_reset_n_in |=> uart_rx_line_out && dec_state_reg == DEC_IDLE)
        else $error("Reception not blocked under decoder reset.");

    a_dec_restart: assert property (
        ir_fall && dec_state_reg == DEC_STRETCH && decoder_reset_n_in
        |=> dec_cnt_reg == 5'h00 && !uart_rx_line_out)
        else $error("Stretch count did not restart on a new edge.");

    a_sync_latency: assert property (
        tx_fall |-> $past(uart_tx_line_in, 3) && !$past(uart_tx_line_in, 2))
        else $error("Transmit edge not seen through two synchroniser stages.");

    c_enc_pulse: cover property ($fell(ir_pulse_out));
    c_dec_stretch: cover property ($rose(uart_rx_line_out) && !$past(dec_hold));
    c_dec_restart: cover property (ir_fall && dec_state_reg == DEC_STRETCH);
    c_fifo_full: cover property (!fifo_in_ready);

endmodule : ir_pulse_encode_decode

// file: include/ir_codec_pkg.sv
// Shared constants and state types for the infrared pulse encoder and decoder.
package ir_codec_pkg;

    // Ticks of the 16x bit clock.
    localparam int                    TICK_CNT_W      = 5;
    localparam logic [TICK_CNT_W-1:0] BIT_TICKS       = 5'h10;
    localparam logic [TICK_CNT_W-1:0] ENC_DELAY_TICKS = 5'h07;
    localparam logic [TICK_CNT_W-1:0] ENC_PULSE_TICKS = 5'h03;
    localparam logic [TICK_CNT_W-1:0] TICK_ZERO       = 5'h00;

    // Event FIFO shape.
    localparam int FIFO_WIDTH_DEF = 1;
    localparam int FIFO_DEPTH_DEF = 16;

    // Synchroniser lanes and their values after reset.
    localparam int         SYNC_LANES = 3;
    localparam int         SYNC_CLK   = 0;
    localparam int         SYNC_TX    = 1;
    localparam int         SYNC_IR    = 2;
    localparam logic [2:0] SYNC_RESET = 3'h6;

    // Level of a space bit on the UART line.
    localparam logic SPACE_LEVEL = 1'h0;

    typedef enum logic [1:0] {
        ENC_IDLE  = 2'b00,
        ENC_WAIT  = 2'b01,
        ENC_PULSE = 2'b10
    } enc_state_type;

    typedef enum logic [0:0] {
        DEC_IDLE    = 1'b0,
        DEC_STRETCH = 1'b1
    } dec_state_type;

endpackage : ir_codec_pkg

// file: core/ir_event_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ir_event_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Draining side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    // Pointers wrap by overflow, so the depth must be a power of two.
    generate
        if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_shape
            $error("ir_event_fifo: WIDTH must be >= 1 and DEPTH a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             do_push;
    logic             do_pop;

    always_comb begin
        in_ready_out  = (count_reg != FULL_COUNT);
        out_valid_out = (count_reg != '0);
        out_data_out  = mem_reg[rd_ptr_reg];
        do_push       = in_valid_in & in_ready_out;
        do_pop        = out_valid_out & out_ready_in;
        wr_ptr_next   = do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next   = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next    = count_reg;
        if (do_push && !do_pop) begin
            count_next = count_reg + 1'b1;
        end else if (do_pop && !do_push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage carries no reset; a word is only read after it was written.
    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

endmodule : ir_event_fifo

// file: sim/far_side_model.sv
// Far-side model: UART bit clock, UART transmit line and transceiver pulses.
`timescale 1ns/1ps
module far_side_model #(
    parameter int TICK_PERIOD = 56
) (
    // Clock
    input  wire logic clk_in,
    // Lines towards the codec
    output logic      tick_clock_out,
    output logic      tx_line_out,
    output logic      ir_line_out
);
    int phase = 0;

    initial begin
        tick_clock_out = 1'b0;
        tx_line_out = 1'b1;
        ir_line_out = 1'b1;
    end

    always @(posedge clk_in) begin
        #1;
        phase = (phase == TICK_PERIOD - 1) ? 0 : phase + 1;
        tick_clock_out = (phase < TICK_PERIOD / 2);
    end

    // Each bit holds for sixteen ticks, least significant first.
    task automatic send_bits(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge tick_clock_out);
            tx_line_out = bits[i];
            repeat (15) @(posedge tick_clock_out);
        end
        @(posedge tick_clock_out);
        tx_line_out = 1'b1;
    endtask : send_bits

    // falls faster than the queue drains
    // Not a legal UART frame; it only exists to drive the event queue past full.
    task automatic burst_tx(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            #1 tx_line_out = 1'b0;
            repeat (3) @(posedge clk_in);
            #1 tx_line_out = 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask : burst_tx

    task automatic send_ir_pulse();
        @(posedge tick_clock_out);
        ir_line_out = 1'b0;
        repeat (3) @(posedge tick_clock_out);
        ir_line_out = 1'b1;
    endtask : send_ir_pulse

endmodule : far_side_model

// file: sim/tb.sv
// Self-checking testbench for the infrared pulse encoder and decoder.
`timescale 1ns/1ps
module tb;
    import ir_codec_pkg::*;
    localparam int T = 56;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic decoder_reset_n = 1'b1;
    logic x16_clk, tx_line, ir_line;
    logic uart_rx_line_out, ir_pulse_out, tx_overrun_out;
    logic tx_q = 1'b1;
    logic ir_q = 1'b0;
    logic rx_q = 1'b1;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int tx_fall_cyc, ir_rise_cyc, rx_fall_cyc, ir_delay, rx_width;
    int ir_count = 0;
    int rx_count = 0;
    int base_ir, base_rx;

    always #5 clk_in = ~clk_in;

    far_side_model #(.TICK_PERIOD(T)) i_far (
        .clk_in         (clk_in),
        .tick_clock_out (x16_clk),
        .tx_line_out    (tx_line),
        .ir_line_out    (ir_line)
    );

    ir_pulse_encode_decode i_dut (
        .clk_in             (clk_in),
        .rst_in             (rst_in),
        .x16_bit_clock_in   (x16_clk),
        .uart_tx_line_in    (tx_line),
        .uart_rx_line_out   (uart_rx_line_out),
        .ir_pulse_in        (ir_line),
        .ir_pulse_out       (ir_pulse_out),
        .decoder_reset_n_in (decoder_reset_n),
        .tx_overrun_out     (tx_overrun_out)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Edge monitor on the lines; widths are counted in system clock cycles.
    always @(posedge clk_in) begin
        cyc++;
        if (tx_line === 1'b0 && tx_q === 1'b1) begin
            tx_fall_cyc = cyc;
        end
        if (ir_pulse_out === 1'b1 && ir_q === 1'b0) begin
            ir_count++;
            ir_rise_cyc = cyc;
            ir_delay = cyc - tx_fall_cyc;
        end
        if (ir_pulse_out === 1'b0 && ir_q === 1'b1) begin
            check(cyc - ir_rise_cyc, int'(ENC_PULSE_TICKS) * T, "pulse width");
        end
        if (uart_rx_line_out === 1'b0 && rx_q === 1'b1) begin
            rx_fall_cyc = cyc;
        end
        if (uart_rx_line_out === 1'b1 && rx_q === 1'b0) begin
            rx_count++;
            rx_width = cyc - rx_fall_cyc;
        end
        tx_q = tx_line;
        ir_q = ir_pulse_out;
        rx_q = uart_rx_line_out;
    end

    function automatic logic [31:0] in_range(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction : in_range

    task automatic ticks(input int n);
        repeat (n) @(posedge x16_clk);
    endtask : ticks

    task automatic t_reset_values();
        check(uart_rx_line_out, 1'b1, "rx idle");
        check(ir_pulse_out, 1'b0, "ir idle");
        check(tx_overrun_out, 1'b0, "overrun idle");
        $display("test reset values done");
    endtask : t_reset_values

    task automatic t_frame(input logic [7:0] data, input int zeros);
        base_ir = ir_count;
        i_far.send_bits({6'h3f, 1'b1, data, 1'b0}, 10);
        ticks(16);
        check(ir_count - base_ir, zeros, "pulses per frame");
        check(tx_overrun_out, 1'b0, "no overrun");
        check(uart_rx_line_out, 1'b1, "rx quiet");
        $display("test frame %0h done", data);
    endtask : t_frame

    // The reset lands while the first event still waits, so no pulse is cut short.
    task automatic t_overrun();
        base_ir = ir_count;
        i_far.burst_tx(20);
        repeat (4) @(posedge clk_in);
        #1 check(tx_overrun_out, 1'b1, "queue overrun");
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        check(tx_overrun_out, 1'b0, "overrun cleared");
        check(ir_pulse_out, 1'b0, "ir after reset");
        check(uart_rx_line_out, 1'b1, "rx after reset");
        @(posedge clk_in);
        #1 check(tx_overrun_out, 1'b0, "overrun stays clear");
        ticks(12);
        check(ir_count - base_ir, 0, "queue flushed");
        check(tx_overrun_out, 1'b0, "no overrun after reset");
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_decode_single();
        base_rx = rx_count;
        i_far.send_ir_pulse();
        ticks(20);
        check(rx_count - base_rx, 1, "one stretch");
        check(in_range(rx_width, 15 * T, int'(BIT_TICKS) * T + 4), 1, "stretch width");
        check(in_range(rx_width, 12 * T, 17 * T), 1, "three quarters");
        check(uart_rx_line_out, 1'b1, "rx back high");
        $display("test decode single done");
    endtask : t_decode_single

    task automatic t_decode_restart();
        base_rx = rx_count;
        i_far.send_ir_pulse();
        ticks(5);
        i_far.send_ir_pulse();
        ticks(24);
        check(rx_count - base_rx, 1, "merged stretch");
        check(in_range(rx_width, 24 * T, 25 * T + 4), 1, "restarted width");
        $display("test decode restart done");
    endtask : t_decode_restart

    task automatic t_decoder_hold();
        @(posedge clk_in);
        #1 decoder_reset_n = 1'b0;
        base_rx = rx_count;
        base_ir = ir_count;
        fork
            i_far.send_ir_pulse();
            i_far.send_bits(16'h0002, 2);
        join
        ticks(12);
        check(rx_count - base_rx, 0, "held decoder");
        check(uart_rx_line_out, 1'b1, "rx held high");
        check(ir_count - base_ir, 1, "encoder runs");
        check(in_range(ir_delay, 7 * T - T / 2, int'(ENC_DELAY_TICKS) * T + T / 2), 1, "delay");
        @(posedge clk_in);
        #1 decoder_reset_n = 1'b1;
        ticks(20);
        check(rx_count - base_rx, 0, "no late stretch");
        $display("test decoder hold done");
    endtask : t_decoder_hold

    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        #1 rst_in = 1'b0;
        t_reset_values();
        t_frame(8'h35, 5);
        t_frame(8'h00, 9);
        t_overrun();
        t_decode_single();
        t_decode_restart();
        t_decoder_hold();
        t_decode_single();
        finish_test();
    end

endmodule : tb
